// [rtl/fwsr_host_ctrl.sv]
/*
 * Host-side controller that watches a flash's program and erase status:
 * runs the toggle-bit algorithm, samples the erase timer bit and issues the
 * reset command, under orders written over AHB-Lite.
 * Assumes a single AHB-Lite master, word accesses, and flash pins
 * synchronous to clk; the ready/busy line is pulled up off chip.
 */
// Summary of operation
// - Host writes reset after timeout failure
// - Ignore timer only with 50us spacing
// - Host checks timer bit around sector commands
// - Host reads status twice, compares toggle bit
// - Toggling plus timeout: recheck, then reset
// - Returning host restarts from first double read
// - Status reads use a valid address
module fwsr_host_ctrl
    import fwsr_pkg::*;
(
    input  wire logic        clk,        // System clock, 100 MHz
    input  wire logic        rst,        // Synchronous reset, active high
    input  wire logic        hsel,       // AHB slave select
    input  wire logic [31:0] haddr,      // AHB address
    input  wire logic [1:0]  htrans,     // AHB transfer type
    input  wire logic        hwrite,     // AHB write
    input  wire logic [2:0]  hsize,      // AHB size, word only
    input  wire logic [31:0] hwdata,     // AHB write data
    input  wire logic        hready,     // AHB bus ready
    output logic             hreadyout,  // Always ready
    output logic             hresp,      // Always OKAY
    output logic [31:0]      hrdata,     // AHB read data
    input  wire logic [7:0]  dqIn,       // Flash data bus in
    input  wire logic        readyBusyN, // Shared ready/busy line level
    output fwsr_pins_t       flashPins   // Flash strobes, address, data out
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_RD1  = 3'b001,
        H_RD2  = 3'b010,
        H_CMP  = 3'b011,
        H_RD3  = 3'b100,
        H_RST  = 3'b101,
        H_TMR  = 3'b110
    } fwsr_host_t;

    localparam int TMR_BOUND = 40;

    // AHB address phase capture
    logic       apWrQ, apWrD;
    logic [3:0] apOfsQ, apOfsD;
    logic       apValid;

    assign apValid = hsel && hready && htrans[1];

    always_comb begin
        apWrD  = apValid && hwrite;
        apOfsD = apValid ? {haddr[3:2], 2'b00} : apOfsQ;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            apWrQ  <= 1'b0;
            apOfsQ <= 4'h0;
        end else begin
            apWrQ  <= apWrD;
            apOfsQ <= apOfsD;
        end
    end

    // Zero wait states; every access completes OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Data phase write decode
    logic       cmdValid;
    logic [7:0] cmdVal;
    logic       addrWr;

    assign cmdValid = apWrQ && (apOfsQ == OFS_CMD);
    assign cmdVal   = hwdata[7:0];
    assign addrWr   = apWrQ && (apOfsQ == OFS_ADDR);

    // Controller state
    fwsr_host_t       stQ, stD;
    logic [FL_AW-1:0] addrQ, addrD;
    logic [7:0]       byteAQ, byteAD;
    logic [7:0]       byteBQ, byteBD;
    logic             okQ, okD;
    logic             failQ, failD;
    logic             timerQ, timerD;
    logic             abortQ, abortD;
    logic             fromFailQ, fromFailD;
    logic             startQ, startD;
    fwsr_req_t        reqQ, reqD;
    logic             engDone;
    logic [7:0]       engData;
    logic             tglDiff;

    // Toggle bit one compared between the two latest status reads
    assign tglDiff = byteAQ[BIT_TOGGLE1] != byteBQ[BIT_TOGGLE1];

    // Command intake and toggle algorithm
    always_comb begin
        stD       = stQ;
        addrD     = addrQ;
        byteAD    = byteAQ;
        byteBD    = byteBQ;
        okD       = okQ;
        failD     = failQ;
        timerD    = timerQ;
        abortD    = abortQ;
        fromFailD = fromFailQ;
        startD    = 1'b0;
        reqD      = reqQ;
        // Address held steady while busy so every status read hits it
        if (addrWr && stQ == H_IDLE) begin
            addrD = hwdata[FL_AW-1:0];
        end
        if (cmdValid && cmdVal == CMD_ABORT && stQ != H_IDLE) begin
            abortD = 1'b1;
        end
        unique case (stQ)
            H_IDLE: begin
                abortD = 1'b0;
                if (cmdValid) begin
                    reqD = '{wr: 1'b0, addr: addrD, data: 8'h00};
                    if (cmdVal == CMD_POLL) begin
                        // Each poll starts over with a fresh pair of reads
                        okD    = 1'b0;
                        failD  = 1'b0;
                        stD    = H_RD1;
                        startD = 1'b1;
                    end else if (cmdVal == CMD_TIMER) begin
                        stD    = H_TMR;
                        startD = 1'b1;
                    end else if (cmdVal == CMD_RESET) begin
                        reqD      = '{wr: 1'b1, addr: addrD, data: RESET_CMD_DATA};
                        fromFailD = 1'b0;
                        stD       = H_RST;
                        startD    = 1'b1;
                    end
                end
            end
            H_RD1: begin
                if (engDone) begin
                    byteAD = engData;
                    stD    = H_RD2;
                    startD = 1'b1;
                end
            end
            H_RD2: begin
                if (engDone) begin
                    byteBD = engData;
                    stD    = H_CMP;
                end
            end
            H_CMP: begin
                if (!tglDiff) begin
                    okD = 1'b1;
                    stD = H_IDLE;
                end else if (abortQ) begin
                    stD = H_IDLE;
                end else if (byteBQ[BIT_TMOFAIL]) begin
                    // Toggle may have stopped just as the timeout bit rose
                    byteAD = byteBQ;
                    stD    = H_RD3;
                    startD = 1'b1;
                end else begin
                    byteAD = byteBQ;
                    stD    = H_RD2;
                    startD = 1'b1;
                end
            end
            H_RD3: begin
                if (engDone) begin
                    byteBD = engData;
                    if (byteAQ[BIT_TOGGLE1] == engData[BIT_TOGGLE1]) begin
                        okD = 1'b1;
                        stD = H_IDLE;
                    end else begin
                        // Still toggling: operation failed, put it back to array read
                        reqD      = '{wr: 1'b1, addr: addrQ, data: RESET_CMD_DATA};
                        fromFailD = 1'b1;
                        stD       = H_RST;
                        startD    = 1'b1;
                    end
                end
            end
            H_RST: begin
                if (engDone) begin
                    failD = fromFailQ;
                    stD   = H_IDLE;
                end
            end
            H_TMR: begin
                if (engDone) begin
                    timerD = engData[BIT_ETIMER];
                    byteBD = engData;
                    stD    = H_IDLE;
                end
            end
            default: stD = H_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stQ       <= H_IDLE;
            addrQ     <= ADDR_RST;
            byteAQ    <= 8'h00;
            byteBQ    <= 8'h00;
            okQ       <= 1'b0;
            failQ     <= 1'b0;
            timerQ    <= 1'b0;
            abortQ    <= 1'b0;
            fromFailQ <= 1'b0;
            startQ    <= 1'b0;
            reqQ      <= '0;
        end else begin
            stQ       <= stD;
            addrQ     <= addrD;
            byteAQ    <= byteAD;
            byteBQ    <= byteBD;
            okQ       <= okD;
            failQ     <= failD;
            timerQ    <= timerD;
            abortQ    <= abortD;
            fromFailQ <= fromFailD;
            startQ    <= startD;
            reqQ      <= reqD;
        end
    end

    // One flash cycle at a time; each state waits for its done
    fwsr_cycle_engine u_engine (
        .clk    (clk),
        .rst    (rst),
        .start  (startQ),
        .req    (reqQ),
        .dqIn   (dqIn),
        .done   (engDone),
        .rdData (engData),
        .pins   (flashPins)
    );

    // Read mux from next values, so a write just ahead is already visible
    logic [31:0] statusD;
    logic [31:0] hrdataQ, hrdataD;

    always_comb begin
        statusD              = 32'h0000_0000;
        statusD[ST_BUSY]     = (stD != H_IDLE);
        statusD[ST_OK]       = okD;
        statusD[ST_FAIL]     = failD;
        statusD[ST_TIMER]    = timerD;
        statusD[ST_READY]    = readyBusyN;
        statusD[ST_BYTE+:8]  = byteBD;
        hrdataD = hrdataQ;
        if (apValid && !hwrite) begin
            unique case ({haddr[3:2], 2'b00})
                OFS_ADDR:   hrdataD = {{(32-FL_AW){1'b0}}, addrD};
                OFS_STATUS: hrdataD = statusD;
                OFS_DATA:   hrdataD = {24'h000000, byteBD};
                default:    hrdataD = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdataQ <= 32'h0000_0000;
        end else begin
            hrdataQ <= hrdataD;
        end
    end

    assign hrdata = hrdataQ;

    // Checks on the controller's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence sPollCmd;
        stQ == H_IDLE && cmdValid && cmdVal == CMD_POLL;
    endsequence

    sequence sTmrCmd;
        stQ == H_IDLE && cmdValid && cmdVal == CMD_TIMER;
    endsequence

    a_double_read_first: assert property (
        (stQ == H_RD1 && engDone) |=> (stQ == H_RD2 && startQ))
        else $error("second status read not issued after first");

    a_done_on_steady: assert property (
        ($rose(okQ) && $past(stQ) == H_CMP) |->
            $past(byteAQ[BIT_TOGGLE1]) == $past(byteBQ[BIT_TOGGLE1]))
        else $error("done reported while toggle bit changed");

    a_recheck_timeout: assert property (
        (stQ == H_CMP && tglDiff && byteBQ[BIT_TMOFAIL] && !abortQ)
            |=> (stQ == H_RD3 && startQ))
        else $error("no recheck after timeout bit seen");

    a_fail_sends_reset: assert property (
        $rose(failQ) |-> ($past(stQ) == H_RST && $past(engDone)
            && $past(reqQ.wr) && $past(reqQ.data) == RESET_CMD_DATA))
        else $error("failure flagged without reset command");

    a_restart_from_top: assert property (
        sPollCmd |=> (stQ == H_RD1 && startQ && !okQ && !failQ))
        else $error("poll did not restart at first read");

    a_status_address: assert property (
        (!flashPins.oeN && stQ != H_IDLE) |-> (flashPins.addr == addrQ))
        else $error("status read at an address other than the set one");

    a_timer_captured: assert property (
        (stQ == H_TMR && engDone) |=> (timerQ == $past(engData[BIT_ETIMER])))
        else $error("erase timer bit not captured");

    a_timer_bounded: assert property (
        sTmrCmd |-> ##[1:TMR_BOUND] (stQ == H_IDLE))
        else $error("erase timer check did not finish in time");
endmodule

// [rtl/fwsr_pkg.sv]
/*
 * Shared constants and carrier types of the flash write-status host controller.
 * Assumes a 100 MHz clock and a byte-wide parallel flash with an open-drain
 * ready/busy line.
 */
package fwsr_pkg;
    // Clock period and pin timing
    localparam int CLK_NS    = 10;
    localparam int T_RC_NS   = 120;  // Read cycle, slowest speed grade
    localparam int T_WP_NS   = 50;   // Write strobe low time, plain default
    localparam int T_OEH_NS  = 10;   // Output enable hold for status reads
    localparam int RD_CYC    = (T_RC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_CYC   = (T_OEH_NS + CLK_NS - 1) / CLK_NS;

    // Register byte offsets on the AHB-Lite slave
    localparam logic [3:0] OFS_CMD    = 4'h0;
    localparam logic [3:0] OFS_ADDR   = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_DATA   = 4'hC;

    // Command codes written to the command register
    localparam logic [7:0] CMD_POLL  = 8'h01;
    localparam logic [7:0] CMD_RESET = 8'h02;
    localparam logic [7:0] CMD_TIMER = 8'h03;
    localparam logic [7:0] CMD_ABORT = 8'h04;

    // Status register fields
    localparam int ST_BUSY  = 0;
    localparam int ST_OK    = 1;
    localparam int ST_FAIL  = 2;
    localparam int ST_TIMER = 3;
    localparam int ST_READY = 4;
    localparam int ST_BYTE  = 8;

    // Status byte bit positions
    localparam int BIT_POLL    = 7;
    localparam int BIT_TOGGLE1 = 6;
    localparam int BIT_TMOFAIL = 5;
    localparam int BIT_ETIMER  = 3;
    localparam int BIT_TOGGLE2 = 2;

    // Flash reset command byte and widths
    localparam logic [7:0] RESET_CMD_DATA = 8'hF0;
    localparam int         FL_AW          = 21;
    localparam logic [FL_AW-1:0] ADDR_RST = 21'h000000;

    typedef struct packed {
        logic             wr;
        logic [FL_AW-1:0] addr;
        logic [7:0]       data;
    } fwsr_req_t;

    typedef struct packed {
        logic             ceN;
        logic             oeN;
        logic             weN;
        logic [FL_AW-1:0] addr;
        logic [7:0]       dqOut;
        logic             dqOe;
    } fwsr_pins_t;

    localparam fwsr_pins_t PINS_IDLE = '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1,
                                         addr: ADDR_RST, dqOut: 8'h00, dqOe: 1'b0};
endpackage

// [rtl/fwsr_cycle_engine.sv]
/*
 * Runs one read or one write cycle on the flash pins and reports its end.
 * Assumes start is pulsed only while idle and that pin inputs are
 * synchronous to clk.
 */
module fwsr_cycle_engine
    import fwsr_pkg::*;
(
    input  wire logic       clk,     // System clock
    input  wire logic       rst,     // Synchronous reset
    input  wire logic       start,   // Begin a cycle
    input  wire fwsr_req_t  req,     // Cycle kind, address, write data
    input  wire logic [7:0] dqIn,    // Flash data bus in
    output logic            done,    // Cycle finished, one pulse
    output logic [7:0]      rdData,  // Byte of the last read
    output fwsr_pins_t      pins     // Registered flash strobes and data
);
    typedef enum logic [1:0] {
        CY_IDLE = 2'b00,
        CY_ACT  = 2'b01,
        CY_GAP  = 2'b10
    } fwsr_cyc_t;

    fwsr_cyc_t  stQ, stD;
    logic [3:0] cntQ, cntD;
    fwsr_req_t  reqQ, reqD;
    logic [7:0] rdQ, rdD;
    logic       doneQ, doneD;
    fwsr_pins_t pinsQ, pinsD;

    // Next state; pins follow the next state so they change on the edge
    always_comb begin
        stD   = stQ;
        cntD  = cntQ;
        reqD  = reqQ;
        rdD   = rdQ;
        doneD = 1'b0;
        unique case (stQ)
            CY_IDLE: begin
                if (start) begin
                    reqD = req;
                    stD  = CY_ACT;
                    cntD = req.wr ? 4'(WR_CYC - 1) : 4'(RD_CYC - 1);
                end
            end
            CY_ACT: begin
                if (cntQ == 4'h0) begin
                    // Sample at the end of the full read cycle time
                    if (!reqQ.wr) begin
                        rdD = dqIn;
                    end
                    stD  = CY_GAP;
                    cntD = 4'(GAP_CYC - 1);
                end else begin
                    cntD = cntQ - 4'h1;
                end
            end
            CY_GAP: begin
                if (cntQ == 4'h0) begin
                    stD   = CY_IDLE;
                    doneD = 1'b1;
                end else begin
                    cntD = cntQ - 4'h1;
                end
            end
            default: stD = CY_IDLE;
        endcase
        pinsD.addr  = reqD.addr;
        pinsD.dqOut = reqD.data;
        pinsD.ceN   = (stD != CY_ACT);
        pinsD.oeN   = !(stD == CY_ACT && !reqD.wr);
        pinsD.weN   = !(stD == CY_ACT && reqD.wr);
        // Write data held through the gap for data hold time
        pinsD.dqOe  = reqD.wr && (stD != CY_IDLE);
    end

    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            stQ   <= CY_IDLE;
            cntQ  <= 4'h0;
            reqQ  <= '0;
            rdQ   <= 8'h00;
            doneQ <= 1'b0;
            pinsQ <= PINS_IDLE;
        end else begin
            stQ   <= stD;
            cntQ  <= cntD;
            reqQ  <= reqD;
            rdQ   <= rdD;
            doneQ <= doneD;
            pinsQ <= pinsD;
        end
    end

    assign done   = doneQ;
    assign rdData = rdQ;
    assign pins   = pinsQ;
endmodule

// [tb/fwsr_flash_model.sv]
/*
 * Behavioural flash that answers the host's read and write cycles with status.
 * Assumes pins synchronous to clk; the bench starts each embedded operation.
 */
module fwsr_flash_model
    import fwsr_pkg::*;
(
    input  wire logic        clk,       // System clock
    input  wire logic        rst,       // Synchronous reset
    input  wire fwsr_pins_t  pins,      // Host strobes, address, data
    input  wire logic        opStart,   // Begin an embedded operation
    input  wire logic        opErase,   // Erase when high, program when low
    input  wire logic        opFail,    // Operation runs past its limit
    input  wire logic        opSusp,    // Erase held in suspend
    input  wire logic [15:0] opReads,   // Busy reads before completion
    input  wire logic [7:0]  opTimer,   // Reads spent in the erase window
    input  wire logic [7:0]  arrayByte, // Array contents at any address
    output logic      [7:0]  dqDrv,     // Data the flash puts on dq
    output logic             rbPullLow, // Open-drain ready/busy pull-down
    output logic      [7:0]  resetSeen  // Reset command writes seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        activeQ, eraseQ, failQ, t1Q, t2Q, rdPrevQ, wrPrevQ;
    logic [15:0] leftQ;
    logic [7:0]  tmrQ;
    wire         reading = !pins.ceN && !pins.oeN;
    wire         writing = !pins.ceN && !pins.weN;

    // Status versus array per read; released bus shows inverted data
    always_ff @(posedge clk) begin
        if (rst) begin
            {activeQ, eraseQ, failQ, t1Q, t2Q, rdPrevQ, wrPrevQ} <= 7'h00;
            leftQ     <= 16'h0000;
            tmrQ      <= 8'h00;
            dqDrv     <= 8'hFF;
            resetSeen <= 8'h00;
        end else begin
            rdPrevQ <= reading;
            wrPrevQ <= writing;
            if (opStart) begin
                {activeQ, eraseQ, failQ} <= {1'b1, opErase, opFail};
                leftQ <= opReads;
                tmrQ  <= opTimer;
            end else if (reading && !rdPrevQ) begin
                if (activeQ && eraseQ && opSusp) begin
                    // Suspended sector: toggle bit one stands, toggle bit two runs
                    t2Q   <= ~t2Q;
                    dqDrv <= {1'b1, t1Q, 1'b0, 2'b00, ~t2Q, 2'b00};
                end else if (activeQ && (leftQ != 16'h0000 || failQ)) begin
                    t1Q <= ~t1Q;
                    t2Q <= eraseQ ? ~t2Q : t2Q;
                    leftQ <= (leftQ != 16'h0000) ? leftQ - 16'h0001 : leftQ;
                    tmrQ  <= (tmrQ != 8'h00) ? tmrQ - 8'h01 : tmrQ;
                    dqDrv <= {eraseQ ? 1'b0 : ~arrayByte[7], ~t1Q, failQ,
                              1'b0, eraseQ && tmrQ == 8'h00,
                              eraseQ ? ~t2Q : t2Q, 2'b00};
                end else begin
                    activeQ <= 1'b0;
                    dqDrv   <= arrayByte;
                end
            end else if (!reading && rdPrevQ) begin
                dqDrv <= ~dqDrv; // Not selected: never leave the old value
            end
            // Reset command latches on the rising write strobe
            if (!writing && wrPrevQ && pins.dqOut == RESET_CMD_DATA) begin
                activeQ   <= 1'b0;
                failQ     <= 1'b0;
                resetSeen <= resetSeen + 8'h01;
            end
        end
    end

    // Suspend releases the line although the erase is not finished
    assign rbPullLow = activeQ && !(eraseQ && opSusp);
endmodule

// [tb/fwsr_host_ctrl_tb_top.sv]
/*
 * Self-checking bench for the flash status host controller.
 * Assumes the flash model beside it and an AHB-Lite master made of tasks.
 */
`define CHK(nm, ex, got) begin checkCount++; if ((got) !== (ex)) begin failCount++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module fwsr_host_ctrl_tb_top
    import fwsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] A_CMD = {28'h0000000, OFS_CMD};
    localparam logic [31:0] A_ADR = {28'h0000000, OFS_ADDR};
    localparam logic [31:0] A_ST  = {28'h0000000, OFS_STATUS};
    localparam logic [31:0] A_DAT = {28'h0000000, OFS_DATA};
    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hresp;
    logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000, hrdata;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic        hreadyout, readyBusyN, rbPullLow, opStart = 1'b0;
    logic        opErase = 1'b0, opFail = 1'b0, opSusp = 1'b0;
    logic [15:0] opReads = 16'h0000;
    logic [7:0]  opTimer = 8'h00, arrayByte = 8'h5A, dqDrv, dqIn, resetSeen;
    fwsr_pins_t  flashPins;
    int          failCount = 0, checkCount = 0;

    // Clock and resolved wires; ready/busy is pulled up off chip
    always #5 clk = ~clk;
    assign dqIn       = flashPins.dqOe ? flashPins.dqOut : dqDrv;
    assign readyBusyN = ~rbPullLow;

    fwsr_host_ctrl fwsr_host_ctrl_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dqIn(dqIn),
        .readyBusyN(readyBusyN), .flashPins(flashPins));
    fwsr_flash_model fwsr_flash_model_i (.clk(clk), .rst(rst), .pins(flashPins),
        .opStart(opStart), .opErase(opErase), .opFail(opFail), .opSusp(opSusp),
        .opReads(opReads), .opTimer(opTimer), .arrayByte(arrayByte), .dqDrv(dqDrv),
        .rbPullLow(rbPullLow), .resetSeen(resetSeen));

    // One AHB-Lite single transfer; waits on hready, never on a cycle count
    task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        `CHK("hresp okay", 1'b0, hresp)
    endtask
    task automatic rdReg(input logic [31:0] a, output logic [31:0] r);
        ahb(1'b0, a, 32'h00000000, r);
    endtask
    task automatic wrReg(input logic [31:0] a, d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask
    task automatic waitIdle(output logic [31:0] s);
        int n;
        n = 0;
        s = 32'h00000001;
        while (s[ST_BUSY] !== 1'b0 && n < 3000) begin
            rdReg(A_ST, s);
            n++;
        end
        `CHK("idle within limit", 1'b0, s[ST_BUSY])
    endtask
    task automatic flashOp(input logic er, fl, input logic [15:0] nr, input logic [7:0] tm);
        @(posedge clk);
        {opErase, opFail, opReads, opTimer} <= {er, fl, nr, tm};
        opStart <= 1'b1;
        @(posedge clk);
        opStart <= 1'b0;
    endtask

    // Reset values, read-only status, address width, command reads back zero
    task automatic testRegs();
        logic [31:0] r;
        rdReg(A_ST, r);
        `CHK("status at reset", 32'h00000010, r)
        wrReg(A_ST, 32'hFFFFFFFF);
        rdReg(A_ST, r);
        `CHK("status read only", 32'h00000010, r)
        wrReg(A_ADR, 32'hFFFFFFFF);
        rdReg(A_ADR, r);
        `CHK("address width", 32'h001FFFFF, r)
        rdReg(A_CMD, r);
        `CHK("command reads zero", 32'h00000000, r)
        rdReg(32'h00000010, r);
        `CHK("offset beyond map", 32'h00000000, r)
        rdReg(A_DAT, r);
        `CHK("data at reset", 32'h00000000, r)
    endtask

    // Poll until the toggle bit stands; nr busy reads first (0 = start no new operation)
    task automatic testPoll(input logic [15:0] nr);
        logic [31:0] s;
        if (nr != 16'h0000) begin
            flashOp(1'b0, 1'b0, nr, 8'h00);
            rdReg(A_ST, s);
            `CHK("ready/busy low", 1'b0, s[ST_READY])
        end
        wrReg(A_CMD, {24'h000000, CMD_POLL});
        waitIdle(s);
        `CHK("poll ok", 1'b1, s[ST_OK])
        `CHK("poll no fail", 1'b0, s[ST_FAIL])
        `CHK("ready after poll", 1'b1, s[ST_READY])
        `CHK("array byte after poll", arrayByte, s[15:8])
        rdReg(A_DAT, s);
        `CHK("data register after poll", {24'h000000, arrayByte}, s)
    endtask

    // Timer bit sampled across the erase window, then the erase is polled out
    task automatic testTimer();
        logic [31:0] s;
        flashOp(1'b1, 1'b0, 16'h0004, 8'h02);
        for (int i = 0; i < 3; i++) begin
            wrReg(A_CMD, {24'h000000, CMD_TIMER});
            waitIdle(s);
            `CHK("erase timer bit", (i == 2), s[ST_TIMER])
            `CHK("polling bit in erase", 1'b0, s[8 + BIT_POLL])
        end
        wrReg(A_CMD, {24'h000000, CMD_POLL});
        waitIdle(s);
        `CHK("erase finished ok", 1'b1, s[ST_OK])
    endtask

    // Toggling with timeout set: recheck, then reset command at the held address
    task automatic testFail();
        logic [31:0] s;
        logic [7:0]  n;
        wrReg(A_ADR, 32'h00012345);
        n = resetSeen;
        flashOp(1'b1, 1'b1, 16'h0003, 8'h00);
        wrReg(A_CMD, {24'h000000, CMD_POLL});
        waitIdle(s);
        `CHK("fail flag", 1'b1, s[ST_FAIL])
        `CHK("no ok on fail", 1'b0, s[ST_OK])
        `CHK("timeout bit seen", 1'b1, s[8 + BIT_TMOFAIL])
        `CHK("reset writes", n + 8'h01, resetSeen)
        `CHK("reset address", 21'h012345, flashPins.addr)
        `CHK("ready after reset", 1'b1, s[ST_READY])
        n = resetSeen;
        wrReg(A_CMD, {24'h000000, CMD_RESET});
        waitIdle(s);
        `CHK("reset command writes", n + 8'h01, resetSeen)
    endtask

    // Erase suspended: steady toggle bit ends the poll, then resume and finish
    task automatic testSuspend();
        logic [31:0] s;
        flashOp(1'b1, 1'b0, 16'h0004, 8'h00);
        opSusp <= 1'b1;
        wrReg(A_CMD, {24'h000000, CMD_POLL});
        waitIdle(s);
        `CHK("suspend ok", 1'b1, s[ST_OK])
        `CHK("suspend polling bit", 1'b1, s[8 + BIT_POLL])
        `CHK("suspend ready", 1'b1, s[ST_READY])
        opSusp <= 1'b0;
        testPoll(16'h0000);
    endtask

    // Abort a long poll, refuse an address write meanwhile, restart afresh
    task automatic testAbort();
        logic [31:0] s;
        flashOp(1'b0, 1'b0, 16'h00C8, 8'h00);
        wrReg(A_CMD, {24'h000000, CMD_POLL});
        repeat (30) @(posedge clk);
        wrReg(A_ADR, 32'h00000001);
        rdReg(A_ADR, s);
        `CHK("address kept while busy", 32'h00012345, s)
        wrReg(A_CMD, {24'h000000, CMD_ABORT});
        waitIdle(s);
        `CHK("abort leaves no ok", 1'b0, s[ST_OK])
        `CHK("abort leaves no fail", 1'b0, s[ST_FAIL])
        testPoll(16'h0000);
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checkCount, failCount);
        if (failCount == 0 && checkCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence after ten reset cycles
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        testRegs();
        testPoll(16'h0000);
        testPoll(16'h0005);
        testTimer();
        testSuspend();
        testFail();
        testAbort();
        summarize();
    end

    // Watchdog well above the expected four thousand cycles
    initial begin
        #400000;
        failCount++;
        summarize();
    end
endmodule
